/* core/scrp_defines.svh */
// Constants for the serial configuration port of the gate driver.
// Assumes a single 250 MHz core clock; serial pins arrive asynchronously.
`ifndef SCRP_DEFINES_SVH
`define SCRP_DEFINES_SVH

`define SCRP_FRAME_BITS  16
`define SCRP_FRAME_CNT   5'h10
`define SCRP_CMD_CNT     5'h05
`define SCRP_CNT_SAT     5'h11
`define SCRP_LAST_BIT    4'hF
`define SCRP_RW_BIT      15
`define SCRP_ADDR_MSB    14
`define SCRP_ADDR_LSB    11
`define SCRP_DATA_MSB    10
`define SCRP_RW_WRITE    1'b0
`define SCRP_RW_READ     1'b1
`define SCRP_PAD_BITS    5'h00
`define SCRP_ADDR_FAULT  4'h0
`define SCRP_ADDR_GATE   4'h1
`define SCRP_ADDR_DRV    4'h2
`define SCRP_ADDR_HS     4'h3
`define SCRP_ADDR_CSA    4'h6
`define SCRP_ADDR_RSVD   4'h7
`define SCRP_CFG_FIRST   2
`define SCRP_CFG_COUNT   5
`define SCRP_LOCK_MSB    10
`define SCRP_LOCK_LSB    8
`define SCRP_LOCK_CODE   3'h6
`define SCRP_UNLOCK_CODE 3'h3
`define SCRP_CFG_DEFAULT 11'h000
`define SCRP_DRV_WR_MASK 11'h3FF
`define SCRP_FULL_MASK   11'h7FF
`define SCRP_ZERO_WORD   11'h000
`define SCRP_PIN_IDLE    5'h08

`endif

/* core/scrp_pkg.sv */
// Types shared by the serial configuration port modules.
// Assumes the constants header is compiled alongside.
package scrp_pkg;
    typedef logic [10:0] scrp_word_t;
    typedef logic [3:0]  scrp_addr_t;
    typedef logic [15:0] scrp_frame_t;
    typedef logic [4:0]  scrp_cnt_t;

    // Gray order along idle -> shift -> end
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_END   = 2'b11
    } scrp_state_t;
endpackage : scrp_pkg

/* core/scrp_reg_if.sv */
// Register access path between frame engine and register store.
// Assumes both ends share the core clock.
interface scrp_reg_if;
    import scrp_pkg::*;
    scrp_addr_t rdAddr;
    scrp_word_t rdData;
    logic       wrEn;
    scrp_addr_t wrAddr;
    scrp_word_t wrData;

    modport engine (output rdAddr, output wrEn, output wrAddr,
                    output wrData, input rdData);
    modport store  (input rdAddr, input wrEn, input wrAddr,
                    input wrData, output rdData);
endinterface : scrp_reg_if

/* core/scrp_sync.sv */
// Two-stage synchroniser, one lane per bit.
// Assumes inputs are quasi-static levels or slow edges.
module scrp_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    import scrp_pkg::*;

    if (WIDTH < 1) begin : g_bad
        $error("scrp_sync: WIDTH must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        logic meta_r;
        logic meta_nxt;
        logic hold_nxt;
        always_comb begin
            meta_nxt = asyncIn[i];
            hold_nxt = meta_r;
        end
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_r     <= RST_VAL[i];
                syncOut[i] <= RST_VAL[i];
            end else begin
                meta_r     <= meta_nxt;
                syncOut[i] <= hold_nxt;
            end
        end
    end
endmodule : scrp_sync

/* core/scrp_regfile.sv */
// Register store: two status words, five configuration words.
// Assumes writes arrive only from completed, checked frames.
`include "scrp_defines.svh"
module scrp_regfile (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         clearIn,
    input  wire scrp_pkg::scrp_word_t         statusFault,
    input  wire scrp_pkg::scrp_word_t         statusGate,
    scrp_reg_if.store                         bus,
    output scrp_pkg::scrp_word_t [4:0]        cfgOut
);
    import scrp_pkg::*;

    scrp_word_t mem_r   [`SCRP_CFG_COUNT];
    scrp_word_t mem_nxt [`SCRP_CFG_COUNT];
    logic       clear;
    logic       locked;

    assign clear  = rst | clearIn;
    assign locked = mem_r[`SCRP_ADDR_HS - `SCRP_CFG_FIRST]
                    [`SCRP_LOCK_MSB:`SCRP_LOCK_LSB] == `SCRP_LOCK_CODE;

    for (genvar i = 0; i < `SCRP_CFG_COUNT; i++) begin : g_ent
        localparam scrp_addr_t ADDR = scrp_addr_t'(i + `SCRP_CFG_FIRST);
        localparam scrp_word_t MASK = (ADDR == `SCRP_ADDR_DRV)
                                      ? `SCRP_DRV_WR_MASK : `SCRP_FULL_MASK;
        always_comb begin
            mem_nxt[i] = mem_r[i];
            if (clear) begin
                mem_nxt[i] = `SCRP_CFG_DEFAULT;
            end else if (bus.wrEn && bus.wrAddr == ADDR) begin
                if (!locked) begin
                    mem_nxt[i] = bus.wrData & MASK;
                end else if (ADDR == `SCRP_ADDR_HS &&
                             bus.wrData[`SCRP_LOCK_MSB:`SCRP_LOCK_LSB]
                             == `SCRP_UNLOCK_CODE) begin
                    // Only the unlock code gets through a locked bank
                    mem_nxt[i][`SCRP_LOCK_MSB:`SCRP_LOCK_LSB] =
                        `SCRP_UNLOCK_CODE;
                end
            end
        end
        always_ff @(posedge clk) begin
            mem_r[i] <= mem_nxt[i];
        end
        assign cfgOut[i] = mem_r[i];
    end

    // Status words have no storage here, so writes cannot reach them
    always_comb begin
        bus.rdData = `SCRP_ZERO_WORD;
        if (bus.rdAddr == `SCRP_ADDR_FAULT) begin
            bus.rdData = statusFault;
        end else if (bus.rdAddr == `SCRP_ADDR_GATE) begin
            bus.rdData = statusGate;
        end else if (bus.rdAddr >= `SCRP_ADDR_DRV &&
                     bus.rdAddr <= `SCRP_ADDR_CSA) begin
            bus.rdData = mem_r[3'(bus.rdAddr - `SCRP_ADDR_DRV)];
        end
    end

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        bus.rdAddr >= `SCRP_ADDR_RSVD |-> bus.rdData == `SCRP_ZERO_WORD;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved address read nonzero");

    property p_clear_default;
        @(posedge clk) disable iff (rst)
        clearIn |=> cfgOut == {`SCRP_CFG_COUNT{`SCRP_CFG_DEFAULT}};
    endproperty
    a_clear_default: assert property (p_clear_default)
        else $error("registers not at default after clear");

    property p_lock_holds;
        @(posedge clk) disable iff (rst)
        (locked && !clearIn && bus.wrEn && bus.wrAddr != `SCRP_ADDR_HS)
        |=> $stable(cfgOut);
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("locked register changed by write");
endmodule : scrp_regfile

/* core/scrp_port.sv */
// Serial configuration port: frame engine, pin synchronisers, registers.
// Assumes the controller's serial clock is far slower than the core
// clock (at least six core cycles per half period) and that status
// inputs change slowly; they are synchronised bit by bit.
`include "scrp_defines.svh"
module scrp_port (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 sclkPin,
    input  wire logic                 chipSelectN,
    input  wire logic                 sdiPin,
    input  wire logic                 sleepMode,
    input  wire logic                 supplyUndervoltageLockout,
    input  wire scrp_pkg::scrp_word_t faultStatusIn,
    input  wire scrp_pkg::scrp_word_t gateStatusIn,
    output logic                      sdoOut,
    output logic                      sdoOe,
    output logic                      frameError,
    output scrp_pkg::scrp_word_t      driverControl,
    output scrp_pkg::scrp_word_t      highSideDrive,
    output scrp_pkg::scrp_word_t      lowSideDrive,
    output scrp_pkg::scrp_word_t      overcurrentCtrl,
    output scrp_pkg::scrp_word_t      senseAmpCtrl
);
    import scrp_pkg::*;

    logic [4:0]                pinSync;
    scrp_word_t                faultS;
    scrp_word_t                gateS;
    logic                      sclkS;
    logic                      csS;
    logic                      sdiS;
    logic                      sleepS;
    logic                      uvloS;
    logic                      sclkD_r;
    logic                      sclkRise;
    logic                      sclkFall;
    scrp_word_t [4:0]          cfgWords;

    scrp_state_t               state_r;
    scrp_state_t               state_nxt;
    scrp_cnt_t                 fallCnt_r;
    scrp_cnt_t                 fallCnt_nxt;
    scrp_cnt_t                 riseCnt_r;
    scrp_cnt_t                 riseCnt_nxt;
    scrp_frame_t               inShift_r;
    scrp_frame_t               inShift_nxt;
    scrp_frame_t               outWord_r;
    scrp_frame_t               outWord_nxt;
    logic                      cmdSeen_r;
    logic                      cmdSeen_nxt;
    logic                      sdo_nxt;
    logic                      sdoOe_nxt;
    logic                      frameErr_nxt;
    logic                      wrEn;

    scrp_reg_if regBus ();

    // Reset values match idle pins: a low select after reset would
    // open a phantom frame and end it with a false frame error
    scrp_sync #(
        .WIDTH   (5),
        .RST_VAL (`SCRP_PIN_IDLE)
    ) u_pinSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn ({sclkPin, chipSelectN, sdiPin, sleepMode,
                   supplyUndervoltageLockout}),
        .syncOut (pinSync)
    );

    scrp_sync #(.WIDTH(22)) u_statusSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn ({faultStatusIn, gateStatusIn}),
        .syncOut ({faultS, gateS})
    );

    assign {sclkS, csS, sdiS, sleepS, uvloS} = pinSync;

    // Edges found on the synchronised clock; up to two core cycles after the pin
    assign sclkRise = sclkS & ~sclkD_r;
    assign sclkFall = ~sclkS & sclkD_r;

    scrp_regfile u_regs (
        .clk         (clk),
        .rst         (rst),
        .clearIn     (sleepS | uvloS),
        .statusFault (faultS),
        .statusGate  (gateS),
        .bus         (regBus.store),
        .cfgOut      (cfgWords)
    );

    assign driverControl   = cfgWords[0];
    assign highSideDrive   = cfgWords[1];
    assign lowSideDrive    = cfgWords[2];
    assign overcurrentCtrl = cfgWords[3];
    assign senseAmpCtrl    = cfgWords[4];

    // After five bits the low nibble of the shifter holds the address
    assign regBus.rdAddr = inShift_r[3:0];
    assign regBus.wrAddr =
        inShift_r[`SCRP_ADDR_MSB:`SCRP_ADDR_LSB];
    assign regBus.wrData = inShift_r[`SCRP_DATA_MSB:0];
    assign regBus.wrEn   = wrEn;

    always_comb begin
        state_nxt    = state_r;
        fallCnt_nxt  = fallCnt_r;
        riseCnt_nxt  = riseCnt_r;
        inShift_nxt  = inShift_r;
        outWord_nxt  = outWord_r;
        cmdSeen_nxt  = cmdSeen_r;
        sdo_nxt      = sdoOut;
        frameErr_nxt = 1'b0;
        wrEn         = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                // Clock and data are not looked at while deselected
                if (!csS && !sleepS) begin
                    state_nxt   = ST_SHIFT;
                    fallCnt_nxt = '0;
                    riseCnt_nxt = '0;
                    inShift_nxt = '0;
                    outWord_nxt = '0;
                    cmdSeen_nxt = 1'b0;
                    sdo_nxt     = 1'b0;
                end
            end
            ST_SHIFT: begin
                if (sleepS) begin
                    // Sleep drops the frame silently, no error raised
                    state_nxt = ST_IDLE;
                end else if (csS) begin
                    state_nxt = ST_END;
                end else begin
                    if (sclkFall) begin
                        inShift_nxt = {inShift_r[14:0], sdiS};
                        if (fallCnt_r != `SCRP_CNT_SAT) begin
                            fallCnt_nxt = fallCnt_r + 5'h01;
                        end
                    end
                    // Old contents captured before any write can land
                    if (fallCnt_r == `SCRP_CMD_CNT && !cmdSeen_r) begin
                        cmdSeen_nxt = 1'b1;
                        outWord_nxt = {`SCRP_PAD_BITS,
                                       regBus.rdData};
                    end
                    if (sclkRise) begin
                        if (riseCnt_r < `SCRP_FRAME_CNT) begin
                            sdo_nxt = outWord_r[`SCRP_LAST_BIT -
                                                riseCnt_r[3:0]];
                            riseCnt_nxt = riseCnt_r + 5'h01;
                        end else begin
                            // Extra clocks shift out zeros
                            sdo_nxt = 1'b0;
                        end
                    end
                end
            end
            ST_END: begin
                state_nxt = ST_IDLE;
                if (fallCnt_r == `SCRP_FRAME_CNT) begin
                    if (inShift_r[`SCRP_RW_BIT] == `SCRP_RW_WRITE
                        && !sleepS) begin
                        wrEn = 1'b1;
                    end
                end else begin
                    frameErr_nxt = 1'b1;
                end
            end
        endcase
        sdoOe_nxt = (state_nxt == ST_SHIFT);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            fallCnt_r  <= '0;
            riseCnt_r  <= '0;
            inShift_r  <= '0;
            outWord_r  <= '0;
            cmdSeen_r  <= 1'b0;
            sdoOut     <= 1'b0;
            sdoOe      <= 1'b0;
            frameError <= 1'b0;
            sclkD_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            fallCnt_r  <= fallCnt_nxt;
            riseCnt_r  <= riseCnt_nxt;
            inShift_r  <= inShift_nxt;
            outWord_r  <= outWord_nxt;
            cmdSeen_r  <= cmdSeen_nxt;
            sdoOut     <= sdo_nxt;
            sdoOe      <= sdoOe_nxt;
            frameError <= frameErr_nxt;
            sclkD_r    <= sclkS;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_hiz_deselect;
        csS |=> !sdoOe;
    endproperty
    a_hiz_deselect: assert property (p_hiz_deselect)
        else $error("output enabled while deselected");

    property p_sleep_quiet;
        sleepS |-> !wrEn ##1 !sdoOe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("port active during sleep");

    property p_frame_error;
        (state_r == ST_END && fallCnt_r != `SCRP_FRAME_CNT)
        |-> !wrEn ##1 frameError;
    endproperty
    a_frame_error: assert property (p_frame_error)
        else $error("bad frame length not flagged");

    property p_write_valid;
        wrEn |-> state_r == ST_END && fallCnt_r == `SCRP_FRAME_CNT
                 && $past(csS);
    endproperty
    a_write_valid: assert property (p_write_valid)
        else $error("write committed outside a valid frame end");

    property p_read_no_write;
        (state_r == ST_END && inShift_r[`SCRP_RW_BIT] == `SCRP_RW_READ)
        |-> !wrEn;
    endproperty
    a_read_no_write: assert property (p_read_no_write)
        else $error("read frame caused a write");

    property p_pad_bits;
        (state_r == ST_SHIFT && !csS && !sleepS && sclkRise
         && riseCnt_r < `SCRP_CMD_CNT) |=> sdoOut == 1'b0;
    endproperty
    a_pad_bits: assert property (p_pad_bits)
        else $error("pad bits not zero");

    property p_data_msb;
        (state_r == ST_SHIFT && !csS && !sleepS && sclkRise
         && riseCnt_r == `SCRP_CMD_CNT)
        |=> sdoOut == $past(outWord_r[`SCRP_DATA_MSB]);
    endproperty
    a_data_msb: assert property (p_data_msb)
        else $error("data not sent msb first after command");

    property p_sample_fall;
        (state_r == ST_SHIFT && !sclkFall) |=> $stable(inShift_r);
    endproperty
    a_sample_fall: assert property (p_sample_fall)
        else $error("input shifted without a falling edge");

    property p_error_pulse;
        frameError |=> !frameError;
    endproperty
    a_error_pulse: assert property (p_error_pulse)
        else $error("frame error held longer than one cycle");

    property p_reply_capture;
        $rose(cmdSeen_r)
        |-> outWord_r == {`SCRP_PAD_BITS, $past(regBus.rdData)};
    endproperty
    a_reply_capture: assert property (p_reply_capture)
        else $error("reply word not taken from addressed register");

    // Clocks past the sixteenth must not leak stale reply bits
    property p_extra_zero;
        (state_r == ST_SHIFT && !csS && !sleepS && sclkRise
         && riseCnt_r == `SCRP_FRAME_CNT) |=> sdoOut == 1'b0;
    endproperty
    a_extra_zero: assert property (p_extra_zero)
        else $error("extra clock shifted out a nonzero bit");

    property p_oe_in_frame;
        (state_r == ST_SHIFT && !csS && !sleepS) |=> sdoOe;
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame)
        else $error("output released while selected");

    property p_start_clean;
        (state_r == ST_IDLE && !csS && !sleepS)
        |=> fallCnt_r == '0 && riseCnt_r == '0 && !cmdSeen_r;
    endproperty
    a_start_clean: assert property (p_start_clean)
        else $error("frame started with stale counters");

    c_write_frame: cover property (wrEn);
    c_read_frame: cover property (state_r == ST_END
        && fallCnt_r == `SCRP_FRAME_CNT
        && inShift_r[`SCRP_RW_BIT] == `SCRP_RW_READ);
    c_frame_error: cover property (frameError);
    c_long_frame: cover property (state_r == ST_END
        && fallCnt_r == `SCRP_CNT_SAT);
    c_idle_noise: cover property (state_r == ST_IDLE && csS && sclkRise);
endmodule : scrp_port

/* sim/scrp_master_model.sv */
// Behavioural serial controller that frames words into the port.
// Assumes the core clock paces it: one serial period is 12 core cycles.
module scrp_master_model (
    input  wire logic clk,
    input  wire logic sdoOut,
    input  wire logic sdoOe,
    output logic      sclk,
    output logic      csN,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HALF = 6;
    localparam int GAP  = 100;

    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end

    // Bits past the sixteenth are sent as zero for overlong frames
    task automatic frame(
        input  logic [15:0] word,
        input  int          nBits,
        output logic [15:0] reply,
        output logic        oeMiss
    );
        reply  = 16'h0000;
        oeMiss = 1'b0;
        @(posedge clk);
        csN <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < nBits; i++) begin
            sclk <= 1'b1;
            sdi  <= (i < 16) ? word[15 - i] : 1'b0;
            repeat (HALF) @(posedge clk);
            sclk   <= 1'b0;
            // A released line reads inverted so a hi-Z sample shows up
            reply  = {reply[14:0], sdoOe ? sdoOut : ~sdoOut};
            oeMiss = oeMiss | (sdoOe !== 1'b1);
            repeat (HALF) @(posedge clk);
        end
        csN <= 1'b1;
        sdi <= ~sdi;
        repeat (GAP) @(posedge clk);
    endtask : frame

    // Deliberate pin activity while deselected; ends with clock low
    task automatic idle_noise(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clk);
            sclk <= ~sclk;
            sdi  <= ~sdi;
        end
    endtask : idle_noise
endmodule : scrp_master_model

/* sim/tb_top.sv */
// Self-checking bench for the serial configuration port.
// Assumes the controller model drives the serial pins.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import scrp_pkg::*;

    localparam int N_ROWS = 18;
    localparam int LIMIT  = 30000;

    typedef struct packed {
        logic [15:0] cmd;
        scrp_word_t  exp;
    } scrp_row_t;

    // Write replies carry previous contents; status reads follow inputs
    scrp_row_t rows [N_ROWS] = '{
        '{16'h17FF, 11'h000}, '{16'h9000, 11'h3FF}, '{16'h18AA, 11'h000},
        '{16'h2555, 11'h000}, '{16'h2AAB, 11'h000}, '{16'h3155, 11'h000},
        '{16'h9800, 11'h0AA}, '{16'hA000, 11'h555}, '{16'hA800, 11'h2AB},
        '{16'hB000, 11'h155}, '{16'h2123, 11'h555}, '{16'hA000, 11'h123},
        '{16'h8000, 11'h5A5}, '{16'h07FF, 11'h5A5}, '{16'h8800, 11'h2C3},
        '{16'h3FFF, 11'h000}, '{16'hB800, 11'h000}, '{16'hC800, 11'h000}
    };

    logic       clk        = 1'b0;
    logic       rst        = 1'b1;
    logic       sleepMode  = 1'b0;
    logic       undervolt  = 1'b0;
    scrp_word_t faultIn    = 11'h5A5;
    scrp_word_t gateIn     = 11'h2C3;
    logic       sclk;
    logic       csN;
    logic       sdi;
    logic       sdoOut;
    logic       sdoOe;
    logic       frameError;
    scrp_word_t drvCtl;
    scrp_word_t hsDrv;
    scrp_word_t lsDrv;
    scrp_word_t ocCtl;
    scrp_word_t saCtl;
    int         nErrors    = 0;
    int         cmpCount   = 0;
    int         errPulses  = 0;
    int         cycles     = 0;
    logic [15:0] junk;
    logic        miss;

    initial begin
        forever #2 clk = ~clk;
    end

    scrp_port uut (
        .clk                       (clk),
        .rst                       (rst),
        .sclkPin                   (sclk),
        .chipSelectN               (csN),
        .sdiPin                    (sdi),
        .sleepMode                 (sleepMode),
        .supplyUndervoltageLockout (undervolt),
        .faultStatusIn             (faultIn),
        .gateStatusIn              (gateIn),
        .sdoOut                    (sdoOut),
        .sdoOe                     (sdoOe),
        .frameError                (frameError),
        .driverControl             (drvCtl),
        .highSideDrive             (hsDrv),
        .lowSideDrive              (lsDrv),
        .overcurrentCtrl           (ocCtl),
        .senseAmpCtrl              (saCtl)
    );

    scrp_master_model master (
        .clk    (clk),
        .sdoOut (sdoOut),
        .sdoOe  (sdoOe),
        .sclk   (sclk),
        .csN    (csN),
        .sdi    (sdi)
    );

    always @(posedge clk) begin
        if (frameError === 1'b1) begin
            errPulses <= errPulses + 1;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            nErrors++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            finalReport();
        end
    end

    task automatic check_word(input scrp_word_t got, input scrp_word_t exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: word %h, expected %h",
                     $time, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: flag %b, expected %b",
                     $time, got, exp);
        end
    endtask : check_flag

    task automatic run(input logic [15:0] cmd, input scrp_word_t exp);
        logic [15:0] reply;
        logic        oeMiss;
        master.frame(cmd, 16, reply, oeMiss);
        check_word(reply[10:0], exp);
        check_flag(oeMiss, 1'b0);
    endtask : run

    task automatic finalReport();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finalReport

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check_word(hsDrv, 11'h000);
        for (int r = 0; r < N_ROWS; r++) begin
            run(rows[r].cmd, rows[r].exp);
        end
        check_word(drvCtl, 11'h3FF);
        check_word(hsDrv, 11'h0AA);
        check_word(lsDrv, 11'h123);
        check_word(ocCtl, 11'h2AB);
        check_word(saCtl, 11'h155);
        check_flag(errPulses == 0, 1'b1);
        // Pin activity while deselected must leave everything alone
        master.idle_noise(20);
        repeat (20) @(posedge clk);
        check_flag(sdoOe, 1'b0);
        check_flag(errPulses == 0, 1'b1);
        // Short and long frames: error pulse and nothing written
        master.frame(16'h2FFF, 15, junk, miss);
        check_flag(errPulses == 1, 1'b1);
        master.frame(16'h2FFF, 17, junk, miss);
        check_flag(errPulses == 2, 1'b1);
        run(16'hA800, 11'h2AB);
        // Locking, writes blocked, unlock touches only the lock field
        run(16'h1EAA, 11'h0AA);
        run(16'h27FF, 11'h123);
        run(16'hA000, 11'h123);
        run(16'h1B11, 11'h6AA);
        run(16'h9800, 11'h3AA);
        run(16'h20F0, 11'h123);
        run(16'hA000, 11'h0F0);
        // Sleep clears configuration and shuts the port
        @(posedge clk);
        sleepMode <= 1'b1;
        repeat (10) @(posedge clk);
        check_word(lsDrv, 11'h000);
        check_word(hsDrv, 11'h000);
        master.frame(16'h27FF, 16, junk, miss);
        check_flag(miss, 1'b1);
        sleepMode <= 1'b0;
        repeat (10) @(posedge clk);
        run(16'hA000, 11'h000);
        check_flag(errPulses == 2, 1'b1);
        // Undervoltage clears configuration
        run(16'h10F0, 11'h000);
        @(posedge clk);
        undervolt <= 1'b1;
        repeat (5) @(posedge clk);
        undervolt <= 1'b0;
        repeat (5) @(posedge clk);
        check_word(drvCtl, 11'h000);
        run(16'h9000, 11'h000);
        // Reset in mid-run clears configuration
        run(16'h2911, 11'h000);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        run(16'hA800, 11'h000);
        finalReport();
    end
endmodule : tb_top
